/* File: src/imu_out_params.svh */
// offsets, timing figures and widths for the imu output register set
// assumes inclusion by bare name from the package and the module
`ifndef IMU_OUT_PARAMS_SVH
`define IMU_OUT_PARAMS_SVH

`define ADDR_W 7
`define WORD_W 16
`define ACCEL_W 32
`define OFS_ACCEL_X_LOW 7'h10
`define OFS_ACCEL_X_HIGH 7'h12
`define OFS_ACCEL_Y_LOW 7'h14
`define OFS_ACCEL_Y_HIGH 7'h16
`define OFS_ACCEL_Z_LOW 7'h18
`define OFS_ACCEL_Z_HIGH 7'h1A
`define OFS_TEMPERATURE 7'h1C
`define OFS_TIME_SINCE_SYNC 7'h1E
`define OFS_UPDATE_COUNT 7'h22
`define CLOCK_PERIOD_PS 4000
`define STAMP_TICK_PS 49020000
`define STAMP_TICK_CYCLES (`STAMP_TICK_PS / `CLOCK_PERIOD_PS)
`define SYNC_MODE_LSB 2
`define SYNC_MODE_SCALED 2'h2
`define WORD_ZERO 16'h0000
`define WORD_MAX 16'hFFFF

`endif

/* File: src/imu_out_pkg.sv */
// types shared by the imu output register set
// assumes the params header is on the include path
`default_nettype none
`include "imu_out_params.svh"

package imu_out_pkg;
  typedef logic [`WORD_W-1:0] word_t;
  typedef logic [`ACCEL_W-1:0] accel_t;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [1:0] sync_mode_t;
endpackage

`default_nettype wire

/* File: src/imu_accel_temp_outputs.sv */
// read-only output registers: acceleration, temperature, time stamp, update count
// assumes the serial front end turns host transfers into one-cycle read and write strobes
// Overview of operation
// - each axis high word is the signed upper 16 bits of acceleration, 2.45 mm/s2 per count.
// - each axis low word holds 16 extra resolution bits below its high word.
// - high and low words of an axis join, high first, into one 32-bit signed value.
// - the x low word reads at byte addresses 0x10 and 0x11 and has no flash copy.
// - the x high word is read-only at byte addresses 0x12 and 0x13 with no reset value.
// - y low word sits at 0x14 and y high word at 0x16, both read-only.
// - z low word sits at 0x18 and z high word at 0x1A, both read-only.
// - the z low word carries the 16 extra resolution bits below the z high word.
// - temperature is signed with zero meaning 0 C and 0.1 C per count.
// - a coarse internal temperature reads at byte address 0x1C.
// - the time stamp at 0x1E is unsigned time since the last sync, 49.02 us per count.
// - the time stamp is meaningful when the sync mode field is 10, scaled sync.
// - each update in scaled sync mode loads the time stamp with its last sample time from the latest sync edge.
`timescale 1ns/1ps
`default_nettype none
`include "imu_out_params.svh"

module imu_accel_temp_outputs
  import imu_out_pkg::*;
#(
  parameter int TICK_CYCLES = `STAMP_TICK_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register access from the serial front end
  input wire logic rd_en,
  input wire logic wr_en,
  input wire addr_t addr,
  input wire word_t wdata,
  output logic [`WORD_W-1:0] rdata_r,
  output logic rvalid_r,
  // sensor data path
  input wire logic sample_valid,
  input wire accel_t accel_x,
  input wire accel_t accel_y,
  input wire accel_t accel_z,
  input wire word_t temperature,
  // external sync and the sync mode field of misc_control
  input wire logic sync_pin,
  input wire sync_mode_t sync_mode
);

  // refuse tick lengths that the 16-bit cycle counter cannot serve
  if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : g_tick_check
    $error("TICK_CYCLES out of range");
  end

  accel_t ax_r, ay_r, az_r;
  word_t temp_r, stamp_r, count_r, tick_cnt_r;
  logic [15:0] cyc_cnt_r;
  logic sync_prev_r;
  logic sync_edge;
  logic scaled;
  word_t rd_nxt;

  // word decode: the byte bit of the address is ignored
  function automatic logic word_hit(input addr_t a, input addr_t ofs);
    return a[`ADDR_W-1:1] == ofs[`ADDR_W-1:1];
  endfunction

  assign sync_edge = sync_pin && !sync_prev_r;
  assign scaled = (sync_mode == `SYNC_MODE_SCALED);

  always_ff @(posedge clock) begin
    if (rst) begin
      sync_prev_r <= 1'b0;
    end else begin
      sync_prev_r <= sync_pin;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || sync_edge) begin
      cyc_cnt_r <= 16'h0000;
      tick_cnt_r <= `WORD_ZERO;
    end else if (cyc_cnt_r == 16'(TICK_CYCLES - 1)) begin
      cyc_cnt_r <= 16'h0000;
      if (tick_cnt_r != `WORD_MAX) begin
        tick_cnt_r <= tick_cnt_r + 16'h0001;
      end
    end else begin
      cyc_cnt_r <= cyc_cnt_r + 16'h0001;
    end
  end

  // only the data path loads these
  always_ff @(posedge clock) begin
    if (sample_valid) begin
      ax_r <= accel_x;
      ay_r <= accel_y;
      az_r <= accel_z;
      temp_r <= temperature;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stamp_r <= `WORD_ZERO;
    end else if (sample_valid && scaled) begin
      stamp_r <= sync_edge ? `WORD_ZERO : tick_cnt_r;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count_r <= `WORD_ZERO;
    end else if (sample_valid) begin
      count_r <= count_r + 16'h0001;
    end
  end

  always_comb begin
    rd_nxt = `WORD_ZERO;
    if (word_hit(addr, `OFS_ACCEL_X_LOW)) begin
      rd_nxt = ax_r[15:0];
    end else if (word_hit(addr, `OFS_ACCEL_X_HIGH)) begin
      rd_nxt = ax_r[31:16];
    end else if (word_hit(addr, `OFS_ACCEL_Y_LOW)) begin
      rd_nxt = ay_r[15:0];
    end else if (word_hit(addr, `OFS_ACCEL_Y_HIGH)) begin
      rd_nxt = ay_r[31:16];
    end else if (word_hit(addr, `OFS_ACCEL_Z_LOW)) begin
      rd_nxt = az_r[15:0];
    end else if (word_hit(addr, `OFS_ACCEL_Z_HIGH)) begin
      rd_nxt = az_r[31:16];
    end else if (word_hit(addr, `OFS_TEMPERATURE)) begin
      rd_nxt = temp_r;
    end else if (word_hit(addr, `OFS_TIME_SINCE_SYNC)) begin
      rd_nxt = stamp_r;
    end else if (word_hit(addr, `OFS_UPDATE_COUNT)) begin
      rd_nxt = count_r;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_r <= `WORD_ZERO;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= rd_en;
      if (rd_en) begin
        rdata_r <= rd_nxt;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  read_latency_a: assert property (rd_en |=> rvalid_r)
    else $error("read not answered next cycle");
  no_spurious_a: assert property (!rd_en |=> !rvalid_r)
    else $error("answer without read");
  x_high_read_a: assert property (
    rd_en && addr == `OFS_ACCEL_X_HIGH && !sample_valid
    |=> rdata_r == ax_r[31:16])
    else $error("x high word wrong");
  x_low_odd_a: assert property (
    rd_en && addr == (`OFS_ACCEL_X_LOW | 7'h01) && !sample_valid |=> rdata_r == ax_r[15:0])
    else $error("x low word wrong at odd byte");
  z_join_a: assert property (
    sample_valid ##1 rd_en && addr == `OFS_ACCEL_Z_HIGH && !sample_valid
    |=> rdata_r == $past(accel_z[31:16], 2))
    else $error("z high word not from captured sample");
  unmapped_zero_a: assert property (
    rd_en && addr == 7'h20 |=> rdata_r == `WORD_ZERO)
    else $error("unmapped read not zero");
  write_ignored_a: assert property (
    wr_en && !sample_valid |=> $stable(ax_r) && $stable(temp_r) && $stable(count_r))
    else $error("write changed data");
  stamp_load_a: assert property (
    sample_valid && scaled && !sync_edge |=> stamp_r == $past(tick_cnt_r))
    else $error("stamp not loaded");
  stamp_hold_a: assert property (
    !(sample_valid && scaled) |=> $stable(stamp_r))
    else $error("stamp changed outside scaled update");
  sync_clear_a: assert property (
    sync_edge |=> tick_cnt_r == `WORD_ZERO && cyc_cnt_r == 16'h0000)
    else $error("sync did not clear time");
  count_step_a: assert property (
    sample_valid |=> count_r == $past(count_r) + 16'h0001)
    else $error("counter did not step");
  y_low_read_a: assert property (
    rd_en && word_hit(addr, `OFS_ACCEL_Y_LOW) && !sample_valid |=> rdata_r == ay_r[15:0])
    else $error("y low word wrong");
  temp_read_a: assert property (
    rd_en && word_hit(addr, `OFS_TEMPERATURE) && !sample_valid |=> rdata_r == temp_r)
    else $error("temperature word wrong");
  stamp_read_a: assert property (
    rd_en && word_hit(addr, `OFS_TIME_SINCE_SYNC) |=> rdata_r == $past(stamp_r))
    else $error("time stamp word wrong");
  count_read_a: assert property (
    rd_en && word_hit(addr, `OFS_UPDATE_COUNT) |=> rdata_r == $past(count_r))
    else $error("update count word wrong");
  tick_step_a: assert property (
    !sync_edge && cyc_cnt_r == 16'(TICK_CYCLES - 1) && tick_cnt_r != `WORD_MAX
    |=> tick_cnt_r == $past(tick_cnt_r) + 16'h0001)
    else $error("time stamp tick missed");

  update_c: cover property (sample_valid ##1 rd_en);
  sync_then_update_c: cover property (sync_edge ##[1:20] sample_valid && scaled);
  write_c: cover property (wr_en && addr == `OFS_ACCEL_X_HIGH);
  odd_byte_read_c: cover property (rd_en && addr[0]);
  unscaled_update_c: cover property (sample_valid && !scaled);

endmodule // imu_accel_temp_outputs

`default_nettype wire

/* File: verification/host_model.sv */
// host model: register reads and writes on the strobe port
// assumes a free-running clock; drives at the falling edge
`timescale 1ns/1ps
`default_nettype none
module host_model
  import imu_out_pkg::*;
(
  // register port
  input wire logic clock,
  output var logic rd_en,
  output var logic wr_en,
  output var addr_t addr,
  output var word_t wdata,
  input wire word_t rdata_r,
  input wire logic rvalid_r
);
  initial begin
    {rd_en, wr_en, addr, wdata} = '0;
  end
  task automatic read_word(input addr_t a, output word_t d, output logic ok);
    ok = 1'b0;
    d = 16'h0000;
    @(negedge clock);
    rd_en = 1'b1;
    addr = a;
    @(negedge clock);
    rd_en = 1'b0;
    // released address must not keep its old value
    addr = ~a;
    repeat (3) begin
      if (!ok && rvalid_r === 1'b1) begin
        ok = 1'b1;
        d = rdata_r;
      end
      if (!ok) @(negedge clock);
    end
  endtask
  task automatic write_word(input addr_t a, input word_t d);
    @(negedge clock);
    {wr_en, addr, wdata} = {1'b1, a, d};
    @(negedge clock);
    {wr_en, addr, wdata} = {1'b0, ~a, ~d};
  endtask
endmodule // host_model
`default_nettype wire

/* File: verification/tb_imu_accel_temp_timestamp_outputs.sv */
// self-checking bench for the imu output register set
// assumes host_model and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_imu_accel_temp_timestamp_outputs;
  import imu_out_pkg::*;
  localparam int TICK = 4;
  logic clock, rst, rd_en, wr_en, rvalid_r, sample_valid, sync_pin;
  addr_t addr;
  word_t wdata, rdata_r, tp, cnt, stamp;
  accel_t ax, ay, az;
  sync_mode_t sync_mode;
  int fail_count, total_checks, seed, k;
  int corner[5] = '{0, 1, 4, 5, 9};
  addr_t ofs[10] = '{7'h10, 7'h12, 7'h14, 7'h16, 7'h18, 7'h1A, 7'h1C, 7'h1E, 7'h20, 7'h22};
  imu_accel_temp_outputs #(.TICK_CYCLES(TICK)) imu_accel_temp_outputs_inst (
    .clock(clock), .rst(rst), .rd_en(rd_en), .wr_en(wr_en), .addr(addr), .wdata(wdata),
    .rdata_r(rdata_r), .rvalid_r(rvalid_r), .sample_valid(sample_valid), .accel_x(ax),
    .accel_y(ay), .accel_z(az), .temperature(tp), .sync_pin(sync_pin), .sync_mode(sync_mode));
  host_model host_model_inst (.clock(clock), .rd_en(rd_en), .wr_en(wr_en), .addr(addr),
    .wdata(wdata), .rdata_r(rdata_r), .rvalid_r(rvalid_r));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check_word(input word_t exp, input word_t got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  function automatic word_t exp_word(input addr_t a);
    word_t w[10];
    w = '{ax[15:0], ax[31:16], ay[15:0], ay[31:16], az[15:0], az[31:16], tp, stamp, 16'h0000, cnt};
    return w[(a - 7'h10) >> 1];
  endfunction
  function automatic word_t exp_stamp(input int waits);
    return (waits == 0) ? 16'h0000 : 16'((waits - 1) / TICK);
  endfunction
  task automatic read_check(input addr_t a);
    word_t d;
    logic ok;
    host_model_inst.read_word(a, d, ok);
    if (ok !== 1'b1) begin
      fail_count++;
      end_of_test();
    end else
      check_word(exp_word(a), d);
  endtask
  task automatic put_sample();
    {ax, ay, az, tp} = {$random(seed), $random(seed), $random(seed), 16'($random(seed))};
    sample_valid = 1'b1;
    // a read in the cycle after the update must see the new sample
    fork
      begin
        @(negedge clock);
        sample_valid = 1'b0;
      end
      read_check(7'h1A);
    join
    cnt++;
  endtask
  initial begin
    seed = 32'h5d4cfeaa;
    {fail_count, total_checks} = '0;
    {rst, sample_valid, sync_pin, sync_mode} = 5'h12;
    {ax, ay, az, tp, cnt, stamp} = '0;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    read_check(7'h22);
    read_check(7'h1E);
    for (int i = 0; i < 12; i++) begin
      k = (i < 5) ? corner[i] : ($random(seed) & 15);
      sync_mode = (i < 5) ? 2'h2 : 2'(i);
      @(negedge clock);
      sync_pin = 1'b1;
      repeat (k) @(negedge clock);
      // stamp loads only in scaled mode
      if (sync_mode == 2'h2) stamp = exp_stamp(k);
      put_sample();
      sync_pin = 1'b0;
      host_model_inst.write_word(ofs[i % 10], 16'($random(seed)));
      foreach (ofs[j]) read_check(ofs[j] | 7'(i & 1));
    end
    // a reset in mid-run clears the counter and the stamp
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    {cnt, stamp} = '0;
    read_check(7'h22);
    read_check(7'h1E);
    end_of_test();
  end
endmodule // tb_imu_accel_temp_timestamp_outputs
`default_nettype wire
